// ===== dbam_pkg.sv
// Purpose: constants and carriers for the direct bank address map
// Assumes: one 10 MHz machine clock, async active-low system reset
// Notes: addresses are byte addresses of the 64 Kbyte CPU space
// How it works
// - one 64 Kbyte space, seven areas decoded
// - I/O area 0x0000-0x007F, memory and direct
// - extended I/O 0x0F80-0x0FFF, memory access only
// - direct operands reach RAM 0x0090-0x00FF
// - 3-bit selector resets zero, no translation
// - direct 0x0000-0x007F always hits I/O
// - selector 1..7 maps 0x0080-0x00FF to windows
// - register area 0x0100-0x01FF, also plain RAM
// - vector table at 0xFFC0-0xFFFF
// - non-volatile register data at 0xFFBB-0xFFBF
// - shared reset pin, out/in enable bits
// - stabilization wait after reset and wake-up
package dbam_pkg;

  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h007F;
  localparam logic [15:0] HOLE_HI = 16'h008F;
  localparam logic [15:0] RAM_LO = 16'h0090;
  localparam logic [15:0] DIR_RAM_HI = 16'h00FF;
  localparam logic [15:0] GPR_LO = 16'h0100;
  localparam logic [15:0] GPR_HI = 16'h01FF;
  localparam logic [15:0] RAM_HI = 16'h047F;
  localparam logic [15:0] XIO_LO = 16'h0F80;
  localparam logic [15:0] XIO_HI = 16'h0FFF;
  localparam logic [15:0] PROG_LO = 16'h8000;
  localparam logic [15:0] NVR_LO = 16'hFFBB;
  localparam logic [15:0] NVR_HI = 16'hFFBF;
  localparam logic [15:0] VEC_LO = 16'hFFC0;
  localparam logic [15:0] WIN_BASE = 16'h0080;
  localparam logic [7:0] DIR_IO_HI = 8'h7F;
  localparam logic [7:0] DIR_HOLE_HI = 8'h8F;
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam int SYSTEM_CONFIG_REG_RESET_IN_ENABLE_BIT_POS = 0;
  localparam int SYSTEM_CONFIG_REG_RESET_OUT_ENABLE_BIT_POS = 1;
  localparam logic [1:0] SYSTEM_CONFIG_REG_RESET = 2'h3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_WAIT_NS = 100000;
  localparam int OSC_WAIT_CYCLES = (OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] OSC_WAIT_LAST = 12'(OSC_WAIT_CYCLES - 1);

  typedef enum logic [1:0] {
    KIND_MEM = 2'h0,
    KIND_DIRECT = 2'h1,
    KIND_GPR = 2'h2,
    KIND_VECTOR = 2'h3
  } dbam_kind_type;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_IO = 3'h1,
    REG_XIO = 3'h2,
    REG_RAM = 3'h3,
    REG_GPR = 3'h4,
    REG_PROG = 3'h5,
    REG_NVR = 3'h6,
    REG_VEC = 3'h7
  } dbam_region_type;

  typedef struct packed {
    logic valid;
    dbam_kind_type kind;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dbam_req_type;

  typedef struct packed {
    logic valid;
    logic write;
    dbam_region_type region;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dbam_acc_type;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } dbam_rsp_type;

endpackage : dbam_pkg

// ===== dbam_stab_timer.sv
// Purpose: oscillation stabilization wait counter
// Assumes: start is a one-cycle pulse
// Notes: runs from reset release without a start pulse
`timescale 1ns/1ps
module dbam_stab_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  output logic done_o
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [11:0] cnt;
  } dbam_tmr_type;

  dbam_tmr_type state;
  dbam_tmr_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.done = 1'b0;
    if (start_i)
    begin
      next_state.busy = 1'b1;
      next_state.cnt = 12'h000;
    end
    else if (state.busy)
    begin
      if (state.cnt == dbam_pkg::OSC_WAIT_LAST)
      begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
      else
      begin
        next_state.cnt = state.cnt + 12'h001;
      end
    end
  end

  // busy at reset: the power-on wait starts by itself
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= '{busy: 1'b1, done: 1'b0, cnt: 12'h000};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign done_o = state.done;

endmodule : dbam_stab_timer

// ===== dbam_top.sv
// Purpose: address decode and direct bank translation for the CPU space
// Assumes: memories answer combinationally in the cycle the access is shown
// Notes: one access in flight; reads answer one edge after being taken
`timescale 1ns/1ps
module dbam_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire dbam_pkg::dbam_req_type cpu_req_i,
  input wire logic bank_wr_i,
  input wire logic [2:0] bank_wdata_i,
  input wire logic system_config_reg_wr_i,
  input wire logic [1:0] system_config_reg_wdata_i,
  input wire logic wake_i,
  input wire logic int_rst_req_i,
  input wire logic [7:0] io_rdata_i,
  input wire logic [7:0] ram_rdata_i,
  input wire logic [7:0] prog_rdata_i,
  input wire logic rst_pin_i,
  input wire logic gpio_out_i,
  input wire logic gpio_dir_i,
  output dbam_pkg::dbam_acc_type mem_acc_o,
  output dbam_pkg::dbam_rsp_type cpu_rsp_o,
  output logic cpu_hold_o,
  output logic [2:0] bank_window_select_o,
  output logic [1:0] system_config_reg_o,
  output logic ext_rst_req_o,
  output logic gpio_in_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o
);

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } dbam_state_type;

  typedef struct packed {
    dbam_state_type fsm;
    logic [2:0] bank;
    logic [1:0] system_config_reg;
    dbam_pkg::dbam_acc_type acc;
    logic rd_pend;
    dbam_pkg::dbam_region_type rd_region;
    dbam_pkg::dbam_rsp_type rsp;
    logic ext_rst;
    logic gpio_in;
    logic pin_oe;
  } dbam_regs_type;

  dbam_regs_type state;
  dbam_regs_type next_state;
  logic tmr_start;
  logic tmr_done;

  // region of a physical address; shared by every access kind
  function automatic dbam_pkg::dbam_region_type region_of(input logic [15:0] a);
    dbam_pkg::dbam_region_type r;
    r = dbam_pkg::REG_NONE;
    if (a <= dbam_pkg::IO_HI)
    begin
      r = dbam_pkg::REG_IO;
    end
    else if (a <= dbam_pkg::HOLE_HI)
    begin
      r = dbam_pkg::REG_NONE;
    end
    // register area lies inside RAM: test it first so it is named
    else if (a >= dbam_pkg::GPR_LO && a <= dbam_pkg::GPR_HI)
    begin
      r = dbam_pkg::REG_GPR;
    end
    else if (a >= dbam_pkg::RAM_LO && a <= dbam_pkg::RAM_HI)
    begin
      r = dbam_pkg::REG_RAM;
    end
    else if (a >= dbam_pkg::XIO_LO && a <= dbam_pkg::XIO_HI)
    begin
      r = dbam_pkg::REG_XIO;
    end
    else if (a >= dbam_pkg::VEC_LO)
    begin
      r = dbam_pkg::REG_VEC;
    end
    else if (a >= dbam_pkg::NVR_LO && a <= dbam_pkg::NVR_HI)
    begin
      r = dbam_pkg::REG_NVR;
    end
    else if (a >= dbam_pkg::PROG_LO)
    begin
      r = dbam_pkg::REG_PROG;
    end
    return r;
  endfunction : region_of

  // direct operand to physical address; valid is low for the hole
  function automatic logic [16:0] direct_map(input logic [7:0] op, input logic [2:0] bank);
    logic [16:0] m;
    m = {1'b0, 16'h0000};
    if (op <= dbam_pkg::DIR_IO_HI)
    begin
      m = {1'b1, 8'h00, op};
    end
    else if (bank == dbam_pkg::BANK_RESET)
    begin
      if (op > dbam_pkg::DIR_HOLE_HI)
      begin
        m = {1'b1, 8'h00, op};
      end
      else
      begin
        m = {1'b0, 16'h0000};
      end
    end
    else
    begin
      // window n starts at 0x80 * (n + 1)
      m = {1'b1, dbam_pkg::WIN_BASE + {6'h00, bank, op[6:0]}};
    end
    return m;
  endfunction : direct_map

  // one timer serves the power-on wait and every wake-up wait
  dbam_stab_timer u_stab (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(tmr_start),
    .done_o(tmr_done)
  );

  always_comb
  begin
    logic [16:0] dm;
    logic [15:0] pa;
    logic hit;
    dbam_pkg::dbam_region_type rg;
    dm = 17'h00000;
    pa = 16'h0000;
    hit = 1'b0;
    rg = dbam_pkg::REG_NONE;
    next_state = state;
    tmr_start = 1'b0;
    next_state.acc.valid = 1'b0;
    next_state.rsp.valid = 1'b0;

    // wait after power-on and after leaving stop or subclock mode,
    // whichever clock source is in use
    case (state.fsm)
      ST_WAIT:
      begin
        if (tmr_done)
        begin
          next_state.fsm = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (wake_i)
        begin
          tmr_start = 1'b1;
          next_state.fsm = ST_WAIT;
        end
      end
      default:
      begin
        next_state.fsm = ST_WAIT;
      end
    endcase

    if (bank_wr_i)
    begin
      next_state.bank = bank_wdata_i;
    end
    if (system_config_reg_wr_i)
    begin
      next_state.system_config_reg = system_config_reg_wdata_i;
    end

    // translate the request into a physical access
    case (cpu_req_i.kind)
      dbam_pkg::KIND_DIRECT:
      begin
        dm = direct_map(cpu_req_i.addr[7:0], state.bank);
        pa = dm[15:0];
        hit = dm[16];
      end
      dbam_pkg::KIND_GPR:
      begin
        pa = dbam_pkg::GPR_LO + {8'h00, cpu_req_i.addr[7:0]};
        hit = 1'b1;
      end
      dbam_pkg::KIND_VECTOR:
      begin
        pa = dbam_pkg::VEC_LO + {10'h000, cpu_req_i.addr[4:0], 1'b0};
        hit = 1'b1;
      end
      default:
      begin
        pa = cpu_req_i.addr;
        hit = 1'b1;
      end
    endcase
    rg = hit ? region_of(pa) : dbam_pkg::REG_NONE;

    // read answer from the region shown in the previous cycle;
    // the memories answer that access combinationally
    next_state.rd_pend = 1'b0;
    if (state.rd_pend)
    begin
      next_state.rsp.valid = 1'b1;
      case (state.rd_region)
        dbam_pkg::REG_IO, dbam_pkg::REG_XIO:
        begin
          next_state.rsp.rdata = io_rdata_i;
        end
        dbam_pkg::REG_RAM, dbam_pkg::REG_GPR:
        begin
          next_state.rsp.rdata = ram_rdata_i;
        end
        dbam_pkg::REG_PROG, dbam_pkg::REG_NVR, dbam_pkg::REG_VEC:
        begin
          next_state.rsp.rdata = prog_rdata_i;
        end
        default:
        begin
          next_state.rsp.rdata = 8'h00;
        end
      endcase
    end

    // requests are ignored while the clock is settling;
    // a wake in the same cycle wins over the request
    if (cpu_req_i.valid && state.fsm == ST_RUN && !wake_i)
    begin
      next_state.acc.addr = pa;
      next_state.acc.region = rg;
      next_state.acc.wdata = cpu_req_i.wdata;
      next_state.acc.write = cpu_req_i.write;
      // program space is read-only here; unmapped writes vanish
      if (cpu_req_i.write)
      begin
        next_state.acc.valid = (rg == dbam_pkg::REG_IO) || (rg == dbam_pkg::REG_XIO)
          || (rg == dbam_pkg::REG_RAM) || (rg == dbam_pkg::REG_GPR);
      end
      else
      begin
        next_state.acc.valid = (rg != dbam_pkg::REG_NONE);
        next_state.rd_pend = 1'b1;
        next_state.rd_region = rg;
      end
    end

    // shared reset pin: reset input or general-purpose I/O, plus
    // an open-drain reset output gated by its own enable;
    // reset input enable low hands the pin to general-purpose I/O
    next_state.gpio_in = rst_pin_i;
    next_state.ext_rst = state.system_config_reg[dbam_pkg::SYSTEM_CONFIG_REG_RESET_IN_ENABLE_BIT_POS] && !rst_pin_i;
    if (state.system_config_reg[dbam_pkg::SYSTEM_CONFIG_REG_RESET_OUT_ENABLE_BIT_POS] && (int_rst_req_i || state.fsm == ST_WAIT))
    begin
      next_state.pin_oe = 1'b1;
    end
    else if (!state.system_config_reg[dbam_pkg::SYSTEM_CONFIG_REG_RESET_IN_ENABLE_BIT_POS])
    begin
      next_state.pin_oe = gpio_dir_i && !gpio_out_i;
    end
    else
    begin
      next_state.pin_oe = 1'b0;
    end
  end

  // pin held low at reset: the device stays in reset until the wait ends
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state.fsm <= ST_WAIT;
      state.bank <= dbam_pkg::BANK_RESET;
      state.system_config_reg <= dbam_pkg::SYSTEM_CONFIG_REG_RESET;
      state.acc <= '0;
      state.rd_pend <= 1'b0;
      state.rd_region <= dbam_pkg::REG_NONE;
      state.rsp <= '0;
      state.ext_rst <= 1'b0;
      state.gpio_in <= 1'b1;
      state.pin_oe <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign mem_acc_o = state.acc;
  assign cpu_rsp_o = state.rsp;
  assign cpu_hold_o = state.fsm[0];
  assign bank_window_select_o = state.bank;
  assign system_config_reg_o = state.system_config_reg;
  assign ext_rst_req_o = state.ext_rst;
  assign gpio_in_o = state.gpio_in;
  // open drain: data fixed low, only the enable moves the pin
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = state.pin_oe;

endmodule : dbam_top

// ===== dbam_top_assertions.sv
// Purpose: port checks for dbam_top
// Assumes: one clock domain, async active-low reset
// Notes: a request counts only on the edge it is taken
`timescale 1ns/1ps
module dbam_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire dbam_pkg::dbam_req_type cpu_req_i,
  input wire logic wake_i,
  input wire logic int_rst_req_i,
  input wire logic system_config_reg_wr_i,
  input wire logic [2:0] bank_window_select_o,
  input wire logic [1:0] system_config_reg_o,
  input wire logic cpu_hold_o,
  input wire dbam_pkg::dbam_acc_type mem_acc_o,
  input wire dbam_pkg::dbam_rsp_type cpu_rsp_o,
  input wire logic rst_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic tk;
  logic [7:0] op;
  logic [2:0] bk;
  assign tk = cpu_req_i.valid && !cpu_hold_o && !wake_i;
  assign op = cpu_req_i.addr[7:0];
  assign bk = bank_window_select_o;
  sequence s_dir;
    tk && cpu_req_i.kind == dbam_pkg::KIND_DIRECT && !cpu_req_i.write;
  endsequence
  sequence s_hole;
    s_dir ##0 (bk == 3'h0 && op[7] && op <= 8'h8F);
  endsequence
  property p_rd;
    tk && !cpu_req_i.write |-> ##2 cpu_rsp_o.valid;
  endproperty
  property p_io;
    s_dir ##0 op <= 8'h7F |=> mem_acc_o.valid && mem_acc_o.addr == {8'h00, $past(op)}
      && mem_acc_o.region == dbam_pkg::REG_IO;
  endproperty
  property p_b0;
    s_dir ##0 (bk == 3'h0 && op >= 8'h90) |=> mem_acc_o.addr == {8'h00, $past(op)};
  endproperty
  property p_win;
    s_dir ##0 (bk != 3'h0 && op[7]) |=> mem_acc_o.valid
      && mem_acc_o.addr == 16'h0080 + {6'h00, $past(bk), $past(op[6:0])};
  endproperty
  property p_hole;
    s_hole |=> !mem_acc_o.valid ##1 cpu_rsp_o.valid && cpu_rsp_o.rdata == 8'h00;
  endproperty
  property p_xio;
    tk && cpu_req_i.kind == dbam_pkg::KIND_MEM && cpu_req_i.addr inside {[16'h0F80:16'h0FFF]}
      |=> mem_acc_o.valid && mem_acc_o.region == dbam_pkg::REG_XIO;
  endproperty
  property p_gpr;
    tk && cpu_req_i.kind == dbam_pkg::KIND_GPR |=> mem_acc_o.addr == {8'h01, $past(op)};
  endproperty
  property p_vec;
    tk && cpu_req_i.kind == dbam_pkg::KIND_VECTOR |=> mem_acc_o.region == dbam_pkg::REG_VEC
      && mem_acc_o.addr == {10'h3FF, $past(cpu_req_i.addr[4:0]), 1'b0};
  endproperty
  property p_nvr;
    tk && cpu_req_i.kind == dbam_pkg::KIND_MEM && cpu_req_i.write
      && cpu_req_i.addr inside {[16'hFFBB:16'hFFBF]} |=> !mem_acc_o.valid;
  endproperty
  property p_oe;
    system_config_reg_o[1] && int_rst_req_i && !system_config_reg_wr_i |=> rst_pin_oe_o;
  endproperty
  property p_wake;
    wake_i && !cpu_hold_o |=> cpu_hold_o [*8];
  endproperty
  a_rd: assert property (p_rd)
    else $error("read got no answer");
  a_io: assert property (p_io)
    else $error("direct io operand moved");
  a_b0: assert property (p_b0)
    else $error("bank zero operand translated");
  a_win: assert property (p_win)
    else $error("bank window address wrong");
  a_hole: assert property (p_hole)
    else $error("hole access not empty");
  a_xio: assert property (p_xio)
    else $error("extended io not decoded");
  a_gpr: assert property (p_gpr)
    else $error("register area address wrong");
  a_vec: assert property (p_vec)
    else $error("vector address wrong");
  a_nvr: assert property (p_nvr)
    else $error("nvr data written");
  a_oe: assert property (p_oe)
    else $error("reset pin not driven");
  a_wake: assert property (p_wake)
    else $error("no wait after wake");
endmodule : dbam_chk
bind dbam_top dbam_chk u_chk (.clk_i, .arst_n_i, .cpu_req_i, .wake_i, .int_rst_req_i, .system_config_reg_wr_i,
  .bank_window_select_o, .system_config_reg_o, .cpu_hold_o, .mem_acc_o, .cpu_rsp_o, .rst_pin_oe_o);

// ===== dbam_mem_model.sv
// Purpose: memories answering the access shown on mem_acc_o
// Assumes: combinational read, one byte
// Notes: each source xors the low address with its own mask
`timescale 1ns/1ps
module dbam_mem_model (
  input wire dbam_pkg::dbam_acc_type acc_i,
  output logic [7:0] io_rdata_o,
  output logic [7:0] ram_rdata_o,
  output logic [7:0] prog_rdata_o
);
  logic [7:0] a;
  // idle bus shows inverted data so a late sample never matches
  assign a = acc_i.valid ? acc_i.addr[7:0] : ~acc_i.addr[7:0];
  assign io_rdata_o = a ^ 8'h11;
  assign ram_rdata_o = a ^ 8'h22;
  assign prog_rdata_o = a ^ 8'h33;
endmodule : dbam_mem_model

// ===== tb_direct_bank_address_map.sv
// Purpose: self-checking bench for dbam_top
// Assumes: inputs change at the falling edge
// Notes: region codes 0 none,1 io,2 xio,3 ram,4 gpr,5 prog,6 nvr,7 vec
`timescale 1ns/1ps
module tb_direct_bank_address_map;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  dbam_pkg::dbam_req_type cpu_req_i = '0;
  logic bank_wr_i = 1'b0;
  logic [2:0] bank_wdata_i = 3'h0;
  logic system_config_reg_wr_i = 1'b0;
  logic [1:0] system_config_reg_wdata_i = 2'h0;
  logic wake_i = 1'b0;
  logic int_rst_req_i = 1'b0;
  logic gpio_out_i = 1'b1;
  logic gpio_dir_i = 1'b0;
  logic pin_ext = 1'b1;
  logic held = 1'b0;
  logic rst_pin_i;
  logic [7:0] io_rd, ram_rd, prog_rd;
  dbam_pkg::dbam_acc_type mem_acc_o;
  dbam_pkg::dbam_rsp_type cpu_rsp_o;
  logic cpu_hold_o, ext_rst_req_o, gpio_in_o, rst_pin_o, rst_pin_oe_o;
  logic [2:0] bank_o;
  logic [1:0] system_config_reg_o;
  int n_errors = 0;
  int checks = 0;
  // open drain with external pull-up
  assign rst_pin_i = rst_pin_oe_o ? rst_pin_o : pin_ext;
  dbam_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cpu_req_i(cpu_req_i), .bank_wr_i(bank_wr_i),
    .bank_wdata_i(bank_wdata_i), .system_config_reg_wr_i(system_config_reg_wr_i), .system_config_reg_wdata_i(system_config_reg_wdata_i), .wake_i(wake_i),
    .int_rst_req_i(int_rst_req_i), .io_rdata_i(io_rd), .ram_rdata_i(ram_rd), .prog_rdata_i(prog_rd),
    .rst_pin_i(rst_pin_i), .gpio_out_i(gpio_out_i), .gpio_dir_i(gpio_dir_i), .mem_acc_o(mem_acc_o),
    .cpu_rsp_o(cpu_rsp_o), .cpu_hold_o(cpu_hold_o), .bank_window_select_o(bank_o), .system_config_reg_o(system_config_reg_o),
    .ext_rst_req_o(ext_rst_req_o), .gpio_in_o(gpio_in_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o));
  dbam_mem_model mem (.acc_i(mem_acc_o), .io_rdata_o(io_rd), .ram_rdata_o(ram_rd), .prog_rdata_o(prog_rd));
  initial forever #50 clk_i = ~clk_i;
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n
  task automatic acc(input logic [1:0] k, input logic wr, input logic [15:0] ad, input logic [2:0] rg,
    input logic [15:0] ea);
    logic ev;
    logic [7:0] er;
    ev = rg != 3'h0 && !held && !(wr && rg >= 3'h5);
    er = rg == 3'h0 ? 8'h00 : ea[7:0] ^ (rg <= 3'h2 ? 8'h11 : rg <= 3'h4 ? 8'h22 : 8'h33);
    @(negedge clk_i);
    cpu_req_i = '{1'b1, dbam_pkg::dbam_kind_type'(k), wr, ad, 8'h3C};
    @(negedge clk_i);
    cpu_req_i.valid = 1'b0;
    chk(mem_acc_o.valid, ev);
    if (ev)
      chk({mem_acc_o.write, mem_acc_o.region, mem_acc_o.addr, wr ? mem_acc_o.wdata : 8'h3C}, {wr, rg, ea, 8'h3C});
    @(negedge clk_i);
    chk(cpu_rsp_o.valid, !wr && !held);
    if (!wr && !held)
      chk(cpu_rsp_o.rdata, er);
  endtask : acc
  task automatic cfg(input logic bw, input logic [2:0] b, input logic [1:0] s);
    @(negedge clk_i);
    bank_wr_i = bw;
    system_config_reg_wr_i = !bw;
    bank_wdata_i = b;
    system_config_reg_wdata_i = s;
    @(negedge clk_i);
    bank_wr_i = 1'b0;
    system_config_reg_wr_i = 1'b0;
    chk(bw ? {3'h0, bank_o} : {4'h0, system_config_reg_o}, bw ? {3'h0, b} : {4'h0, s});
  endtask : cfg
  task automatic sc_reset();
    wait_n(8);
    chk({bank_o, system_config_reg_o, cpu_hold_o, rst_pin_oe_o, mem_acc_o.valid, cpu_rsp_o.valid}, {3'h0, 2'h3, 4'hC});
    arst_n_i = 1'b1;
    wait_n(dbam_pkg::OSC_WAIT_CYCLES);
    chk(cpu_hold_o, 1'b1);
    chk({rst_pin_oe_o, ext_rst_req_o}, 2'h3);
    wait_n(1);
    chk(cpu_hold_o, 1'b0);
  endtask : sc_reset
  task automatic sc_banks();
    logic [15:0] ea;
    for (int b = 0; b < 8; b++)
    begin
      cfg(1'b1, b[2:0], 2'h0);
      acc(2'h1, 1'b0, 16'h0020, 3'h1, 16'h0020);
      ea = 16'(16'h0080 * (b + 1) + 16'h007F);
      acc(2'h1, 1'b0, 16'h00FF, (b == 1 || b == 2) ? 3'h4 : 3'h3, ea);
    end
    acc(2'h1, 1'b1, 16'h0080, 3'h3, 16'h0400);
    cfg(1'b1, 3'h0, 2'h0);
    acc(2'h1, 1'b0, 16'h0085, 3'h0, 16'h0000);
    acc(2'h1, 1'b1, 16'h0088, 3'h0, 16'h0000);
    acc(2'h1, 1'b0, 16'h0090, 3'h3, 16'h0090);
  endtask : sc_banks
  task automatic sc_areas();
    acc(2'h0, 1'b0, 16'h0010, 3'h1, 16'h0010);
    acc(2'h0, 1'b0, 16'h0F80, 3'h2, 16'h0F80);
    acc(2'h0, 1'b1, 16'h0FFF, 3'h2, 16'h0FFF);
    acc(2'h0, 1'b0, 16'h0085, 3'h0, 16'h0000);
    acc(2'h0, 1'b1, 16'h047F, 3'h3, 16'h047F);
    acc(2'h2, 1'b0, 16'h0034, 3'h4, 16'h0134);
    acc(2'h0, 1'b1, 16'h01FF, 3'h4, 16'h01FF);
    acc(2'h3, 1'b0, 16'h001F, 3'h7, 16'hFFFE);
    acc(2'h3, 1'b0, 16'h0000, 3'h7, 16'hFFC0);
    acc(2'h0, 1'b0, 16'hFFBB, 3'h6, 16'hFFBB);
    acc(2'h0, 1'b1, 16'hFFBF, 3'h6, 16'hFFBF);
    acc(2'h0, 1'b1, 16'h8000, 3'h5, 16'h8000);
    acc(2'h0, 1'b0, 16'h8000, 3'h5, 16'h8000);
  endtask : sc_areas
  task automatic sc_pin();
    cfg(1'b0, 3'h0, 2'h2);
    int_rst_req_i = 1'b1;
    wait_n(2);
    chk(rst_pin_oe_o, 1'b1);
    int_rst_req_i = 1'b0;
    gpio_dir_i = 1'b1;
    gpio_out_i = 1'b0;
    wait_n(3);
    chk({rst_pin_oe_o, gpio_in_o}, 2'h2);
    gpio_out_i = 1'b1;
    wait_n(3);
    chk({rst_pin_oe_o, gpio_in_o}, 2'h1);
    cfg(1'b0, 3'h0, 2'h1);
    pin_ext = 1'b0;
    wait_n(3);
    chk({rst_pin_oe_o, ext_rst_req_o}, 2'h1);
    pin_ext = 1'b1;
    wait_n(3);
    chk(ext_rst_req_o, 1'b0);
  endtask : sc_pin
  task automatic sc_wake();
    @(negedge clk_i);
    wake_i = 1'b1;
    @(negedge clk_i);
    wake_i = 1'b0;
    chk(cpu_hold_o, 1'b1);
    held = 1'b1;
    acc(2'h0, 1'b0, 16'h0010, 3'h0, 16'h0000);
    held = 1'b0;
    wait_n(dbam_pkg::OSC_WAIT_CYCLES - 3);
    chk(cpu_hold_o, 1'b1);
    wait_n(1);
    chk(cpu_hold_o, 1'b0);
  endtask : sc_wake
  initial
  begin
    // about 2150 cycles of tests, margin for a slow wait
    #(4000 * 100);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    sc_reset();
    sc_banks();
    sc_areas();
    sc_pin();
    sc_wake();
    give_verdict();
  end
endmodule : tb_direct_bank_address_map
